// ---- ccpm_consts.svh ----
// Offsets, field positions, reset values and layout of the camera/card pin multiplexer.
// Assumes inclusion by ccpm_pkg.sv and by the multiplexer module.
`ifndef CCPM_CONSTS_SVH
`define CCPM_CONSTS_SVH

// ==================================================
// Register groups, one aligned word per port
`define CCPM_BASE_SEL 8'h00
`define CCPM_BASE_GOUT 8'h10
`define CCPM_BASE_GDIR 8'h20
`define CCPM_BASE_LEVEL 8'h30
`define CCPM_GRP_SEL 2'h0
`define CCPM_GRP_GOUT 2'h1
`define CCPM_GRP_GDIR 2'h2
`define CCPM_GRP_LEVEL 2'h3
`define CCPM_GRP_LSB 4
`define CCPM_PORT_LSB 2
`define CCPM_MAP_TOP_LSB 6

// ==================================================
// Port indices
`define CCPM_PORT_F 2'h0
`define CCPM_PORT_G 2'h1
`define CCPM_PORT_H 2'h2
`define CCPM_PORT_I 2'h3

// ==================================================
// Pads present per port and reset values
`define CCPM_PADS_FULL 8'hff
`define CCPM_PADS_I 8'h01
`define CCPM_SEL_RESET 16'h0000
`define CCPM_GOUT_RESET 8'h00
`define CCPM_GDIR_RESET 8'h00

// ==================================================
// Bus answers
`define CCPM_RESP_OKAY 2'b00
`define CCPM_RESP_SLVERR 2'b10

`endif

// ---- ccpm_far_side.sv ----
// Far-side model: two cameras on ports F/G, a card on port H, a pull-up on port I.
// Assumes the device drives a pad exactly while its enable is low.
`timescale 1ns/100ps
`default_nettype none
module ccpm_far_side (
	// Clock
	input wire logic aclk,
	// Device pad drive
	input wire logic [7:0] pad_f_out,
	input wire logic [7:0] pad_f_oe_n,
	input wire logic [7:0] pad_g_out,
	input wire logic [7:0] pad_g_oe_n,
	input wire logic [7:0] pad_h_out,
	input wire logic [7:0] pad_h_oe_n,
	input wire logic pad_i_out,
	input wire logic pad_i_oe_n,
	// Bench-set sensor and card levels
	input wire logic slow_pclk,
	input wire logic [2:0] cam_syncs,
	input wire logic [7:0] cam_data,
	input wire logic [7:0] card_lines,
	// Resolved pad levels
	output logic [7:0] pad_f_in,
	output logic [7:0] pad_g_in,
	output logic [7:0] pad_h_in,
	output logic pad_i_in
);
	// ==========
	// Pixel clocks echo the base clocks, one or two cycles late
	logic [1:0] pclk_q;
	logic [1:0] pclk_d;
	logic [1:0] pclk;
	logic [7:0] cam_f;
	always_ff @(posedge aclk) begin
		pclk_q <= {pad_f_out[6] & ~pad_f_oe_n[6], pad_f_out[2] & ~pad_f_oe_n[2]};
		pclk_d <= pclk_q;
	end
	assign pclk = slow_pclk ? pclk_d : pclk_q;
	// ==========
	// Undriven camera-side lines show the inverse of the last value
	assign cam_f = {pclk[1], ~pad_f_out[6], cam_syncs[2:1], pclk[0], ~pad_f_out[2],
		cam_syncs[0], ~pad_f_out[0]};
	assign pad_f_in = (pad_f_oe_n & cam_f) | (~pad_f_oe_n & pad_f_out);
	assign pad_g_in = (pad_g_oe_n & cam_data) | (~pad_g_oe_n & pad_g_out);
	assign pad_h_in = (pad_h_oe_n & card_lines) | (~pad_h_oe_n & pad_h_out);
	assign pad_i_in = pad_i_oe_n | pad_i_out;
endmodule
`default_nettype wire

// ---- ccpm_pin_mux.sv ----
// Pin multiplexer for camera ports F/G and card ports H/I, with AXI4-Lite registers.
// Assumes one 250 MHz clock, synchronous active-low reset, pads on the outside.
//
// Operation
// - Pads come out of reset as GPIO
// - Port F 3:2,5:4,7:6 camera one sync/clocks
// - Port F 9:8..15:14 camera two sync/clocks
// - Port G fields alt one: camera two data
// - Port H 1:0,3:2 card enables or SD data
// - Port H 5:4,7:6 IO strobes or SD data
// - Port H 9:8 wait input or SD command
// - Port H 11:10 card reset or SD clock
// - Port H 13:12 card irq or SD detect
// - Port H 15:14 status change or SD protect
// - Port I 1:0 buffer enable or SD output
// - Base clocks out, pixel clocks in
`timescale 1ns/100ps
`default_nettype none
`include "ccpm_consts.svh"

module ccpm_pin_mux
	import ccpm_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pads
	input wire logic [7:0] pad_f_in,
	output logic [7:0] pad_f_out,
	output logic [7:0] pad_f_oe_n,
	input wire logic [7:0] pad_g_in,
	output logic [7:0] pad_g_out,
	output logic [7:0] pad_g_oe_n,
	input wire logic [7:0] pad_h_in,
	output logic [7:0] pad_h_out,
	output logic [7:0] pad_h_oe_n,
	input wire logic pad_i_in,
	output logic pad_i_out,
	output logic pad_i_oe_n,
	// Camera controllers
	output logic cam_one_line_sync,
	input wire logic cam_one_base_clock_out,
	output logic cam_one_pixel_clock_in,
	output logic cam_two_frame_sync,
	output logic cam_two_line_sync,
	input wire logic cam_two_base_clock_out,
	output logic cam_two_pixel_clock_in,
	output logic [7:0] cam_two_pixel_bus,
	// Card controller
	input wire logic card_enable_high_n,
	input wire logic card_enable_low_n,
	input wire logic card_io_read_strobe_n,
	input wire logic card_io_write_strobe_n,
	output logic card_wait_request_n,
	input wire logic card_reset_out,
	output logic card_interrupt_in,
	output logic card_status_change_n,
	input wire logic card_buffer_enable_n,
	// SD controller
	input wire logic [3:0] sd_data_line_out,
	input wire logic [3:0] sd_data_line_oe_n,
	output logic [3:0] sd_data_line_in,
	input wire logic sd_command_line_out,
	input wire logic sd_command_line_oe_n,
	output logic sd_command_line_in,
	input wire logic sd_clock_out,
	output logic sd_card_detect_n,
	output logic sd_write_protect,
	input wire logic sd_general_output
);

	// ==================================================
	// Helpers
	function automatic ccpm_fn_e fn_of(input logic [15:0] sel, input logic [2:0] pad);
		logic [1:0] code;
		code = sel[{pad, 1'b0} +: 2];
		case (code)
			2'b01: fn_of = CCPM_FN_ALT1;
			2'b10: fn_of = CCPM_FN_ALT2;
			default: fn_of = CCPM_FN_GPIO;
		endcase
	endfunction

	function automatic ccpm_pads_t pads_of(input logic [1:0] port);
		pads_of = (port == `CCPM_PORT_I) ? `CCPM_PADS_I : `CCPM_PADS_FULL;
	endfunction

	function automatic logic [15:0] sel_mask(input logic [1:0] port);
		logic [7:0] pads;
		pads = pads_of(port);
		for (int k = 0; k < 8; k++) begin
			sel_mask[2*k +: 2] = {2{pads[k]}};
		end
	endfunction

	function automatic logic in_map(input logic [ADDR_W-1:0] addr);
		in_map = (addr >> `CCPM_MAP_TOP_LSB) == '0;
	endfunction

	// ==================================================
	// Registers
	logic [15:0] sel_reg [4];
	logic [7:0] gout_reg [4];
	logic [7:0] gdir_reg [4];
	logic [7:0] sync1_reg [4];
	logic [7:0] sync2_reg [4];
	logic [7:0] sync3_reg [4];
	logic [7:0] level_reg [4];
	logic [7:0] pad_in_all [4];
	logic [7:0] out_next [4];
	logic [7:0] oe_n_next [4];
	logic [7:0] out_reg [4];
	logic [7:0] oe_n_reg [4];

	// ==================================================
	// AXI4-Lite slave
	logic aw_held_reg;
	logic w_held_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic do_write;
	logic [1:0] wr_port;
	logic [1:0] wr_grp;
	logic [1:0] rd_port;
	logic [1:0] rd_grp;
	logic [15:0] wr_mask;

	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign wr_mask = sel_mask(wr_port);
	assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = aw_held_reg && w_held_reg;
	assign wr_port = aw_addr_reg[`CCPM_PORT_LSB +: 2];
	assign wr_grp = aw_addr_reg[`CCPM_GRP_LSB +: 2];
	assign rd_port = s_axi_araddr[`CCPM_PORT_LSB +: 2];
	assign rd_grp = s_axi_araddr[`CCPM_GRP_LSB +: 2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end else if (do_write) begin
			w_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CCPM_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= in_map(aw_addr_reg) ? `CCPM_RESP_OKAY : `CCPM_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Register writes with byte lanes; reset selects GPIO everywhere
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int p = 0; p < 4; p++) begin
				sel_reg[p] <= `CCPM_SEL_RESET;
				gout_reg[p] <= `CCPM_GOUT_RESET;
				gdir_reg[p] <= `CCPM_GDIR_RESET;
			end
		end else if (do_write && in_map(aw_addr_reg)) begin
			case (wr_grp)
				`CCPM_GRP_SEL: begin
					if (w_strb_reg[0])
						sel_reg[wr_port][7:0] <= w_data_reg[7:0] & wr_mask[7:0];
					if (w_strb_reg[1])
						sel_reg[wr_port][15:8] <= w_data_reg[15:8] & wr_mask[15:8];
				end
				`CCPM_GRP_GOUT: begin
					if (w_strb_reg[0])
						gout_reg[wr_port] <= w_data_reg[7:0] & pads_of(wr_port);
				end
				`CCPM_GRP_GDIR: begin
					if (w_strb_reg[0])
						gdir_reg[wr_port] <= w_data_reg[7:0] & pads_of(wr_port);
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `CCPM_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= in_map(s_axi_araddr) ? `CCPM_RESP_OKAY : `CCPM_RESP_SLVERR;
			if (!in_map(s_axi_araddr)) begin
				s_axi_rdata <= 32'h0000_0000;
			end else begin
				case (rd_grp)
					`CCPM_GRP_SEL: s_axi_rdata <= {16'h0000, sel_reg[rd_port]};
					`CCPM_GRP_GOUT: s_axi_rdata <= {24'h000000, gout_reg[rd_port]};
					`CCPM_GRP_GDIR: s_axi_rdata <= {24'h000000, gdir_reg[rd_port]};
					default: s_axi_rdata <= {24'h000000, level_reg[rd_port] & pads_of(rd_port)};
				endcase
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==================================================
	// Pad input synchronisers, change taken when stages 2 and 3 agree
	always_comb begin
		pad_in_all[0] = pad_f_in;
		pad_in_all[1] = pad_g_in;
		pad_in_all[2] = pad_h_in;
		pad_in_all[3] = {7'h00, pad_i_in};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int p = 0; p < 4; p++) begin
				sync1_reg[p] <= 8'h00;
				sync2_reg[p] <= 8'h00;
				sync3_reg[p] <= 8'h00;
				level_reg[p] <= 8'h00;
			end
		end else begin
			for (int p = 0; p < 4; p++) begin
				sync1_reg[p] <= pad_in_all[p];
				sync2_reg[p] <= sync1_reg[p];
				sync3_reg[p] <= sync2_reg[p];
				for (int k = 0; k < 8; k++) begin
					if (sync2_reg[p][k] == sync3_reg[p][k])
						level_reg[p][k] <= sync3_reg[p][k];
				end
			end
		end
	end

	// ==================================================
	// Pad drive selection
	always_comb begin
		for (int p = 0; p < 4; p++) begin
			out_next[p] = gout_reg[p];
			oe_n_next[p] = ~gdir_reg[p];
		end
		// Port F: camera syncs and clocks
		for (int k = 1; k < 8; k++) begin
			if (fn_of(sel_reg[0], 3'(k)) == CCPM_FN_ALT1) begin
				oe_n_next[0][k] = 1'b1;
			end
		end
		if (fn_of(sel_reg[0], 3'd2) == CCPM_FN_ALT1) begin
			out_next[0][2] = cam_one_base_clock_out;
			oe_n_next[0][2] = 1'b0;
		end
		if (fn_of(sel_reg[0], 3'd6) == CCPM_FN_ALT1) begin
			out_next[0][6] = cam_two_base_clock_out;
			oe_n_next[0][6] = 1'b0;
		end
		// Port G: camera two pixel bus
		for (int k = 0; k < 8; k++) begin
			if (fn_of(sel_reg[1], 3'(k)) == CCPM_FN_ALT1)
				oe_n_next[1][k] = 1'b1;
		end
		// Port H: card or SD
		for (int k = 0; k < 8; k++) begin
			if (fn_of(sel_reg[2], 3'(k)) == CCPM_FN_ALT1) begin
				oe_n_next[2][k] = 1'b0;
				case (k)
					0: out_next[2][k] = card_enable_high_n;
					1: out_next[2][k] = card_enable_low_n;
					2: out_next[2][k] = card_io_read_strobe_n;
					3: out_next[2][k] = card_io_write_strobe_n;
					5: out_next[2][k] = card_reset_out;
					default: oe_n_next[2][k] = 1'b1;
				endcase
			end else if (fn_of(sel_reg[2], 3'(k)) == CCPM_FN_ALT2) begin
				oe_n_next[2][k] = 1'b1;
				if (k < 4) begin
					out_next[2][k] = sd_data_line_out[k];
					oe_n_next[2][k] = sd_data_line_oe_n[k];
				end else if (k == 4) begin
					out_next[2][k] = sd_command_line_out;
					oe_n_next[2][k] = sd_command_line_oe_n;
				end else if (k == 5) begin
					out_next[2][k] = sd_clock_out;
					oe_n_next[2][k] = 1'b0;
				end
			end
		end
		// Port I: buffer enable or SD output
		if (fn_of(sel_reg[3], 3'd0) == CCPM_FN_ALT1) begin
			out_next[3][0] = card_buffer_enable_n;
			oe_n_next[3][0] = 1'b0;
		end else if (fn_of(sel_reg[3], 3'd0) == CCPM_FN_ALT2) begin
			out_next[3][0] = sd_general_output;
			oe_n_next[3][0] = 1'b0;
		end
		oe_n_next[3][7:1] = 7'h7f;
		out_next[3][7:1] = 7'h00;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int p = 0; p < 4; p++) begin
				out_reg[p] <= 8'h00;
				oe_n_reg[p] <= 8'hff;
			end
		end else begin
			for (int p = 0; p < 4; p++) begin
				out_reg[p] <= out_next[p];
				oe_n_reg[p] <= oe_n_next[p];
			end
		end
	end

	assign pad_f_out = out_reg[0];
	assign pad_f_oe_n = oe_n_reg[0];
	assign pad_g_out = out_reg[1];
	assign pad_g_oe_n = oe_n_reg[1];
	assign pad_h_out = out_reg[2];
	assign pad_h_oe_n = oe_n_reg[2];
	assign pad_i_out = out_reg[3][0];
	assign pad_i_oe_n = oe_n_reg[3][0];

	// ==================================================
	// Peripheral-side inputs, idle level when not routed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cam_one_line_sync <= 1'b0;
			cam_one_pixel_clock_in <= 1'b0;
			cam_two_frame_sync <= 1'b0;
			cam_two_line_sync <= 1'b0;
			cam_two_pixel_clock_in <= 1'b0;
			cam_two_pixel_bus <= 8'h00;
			card_wait_request_n <= 1'b1;
			card_interrupt_in <= 1'b0;
			card_status_change_n <= 1'b1;
			sd_data_line_in <= 4'hf;
			sd_command_line_in <= 1'b1;
			sd_card_detect_n <= 1'b1;
			sd_write_protect <= 1'b0;
		end else begin
			cam_one_line_sync <= (fn_of(sel_reg[0], 3'd1) == CCPM_FN_ALT1) && level_reg[0][1];
			cam_one_pixel_clock_in <= (fn_of(sel_reg[0], 3'd3) == CCPM_FN_ALT1) && level_reg[0][3];
			cam_two_frame_sync <= (fn_of(sel_reg[0], 3'd4) == CCPM_FN_ALT1) && level_reg[0][4];
			cam_two_line_sync <= (fn_of(sel_reg[0], 3'd5) == CCPM_FN_ALT1) && level_reg[0][5];
			cam_two_pixel_clock_in <= (fn_of(sel_reg[0], 3'd7) == CCPM_FN_ALT1) && level_reg[0][7];
			for (int k = 0; k < 8; k++) begin
				cam_two_pixel_bus[k] <= (fn_of(sel_reg[1], 3'(k)) == CCPM_FN_ALT1) && level_reg[1][k];
			end
			for (int k = 0; k < 4; k++) begin
				sd_data_line_in[k] <= (fn_of(sel_reg[2], 3'(k)) == CCPM_FN_ALT2) ? level_reg[2][k] : 1'b1;
			end
			card_wait_request_n <= (fn_of(sel_reg[2], 3'd4) == CCPM_FN_ALT1) ? level_reg[2][4] : 1'b1;
			sd_command_line_in <= (fn_of(sel_reg[2], 3'd4) == CCPM_FN_ALT2) ? level_reg[2][4] : 1'b1;
			card_interrupt_in <= (fn_of(sel_reg[2], 3'd6) == CCPM_FN_ALT1) && level_reg[2][6];
			sd_card_detect_n <= (fn_of(sel_reg[2], 3'd6) == CCPM_FN_ALT2) ? level_reg[2][6] : 1'b1;
			card_status_change_n <= (fn_of(sel_reg[2], 3'd7) == CCPM_FN_ALT1) ? level_reg[2][7] : 1'b1;
			sd_write_protect <= (fn_of(sel_reg[2], 3'd7) == CCPM_FN_ALT2) && level_reg[2][7];
		end
	end

endmodule
`default_nettype wire

// ---- ccpm_pin_mux_props.sv ----
// Checker for the camera/card pin multiplexer, watching its ports only.
// Assumes full-word select writes and port F GPIO direction left at input.
`timescale 1ns/100ps
`default_nettype none
module ccpm_pin_mux_props #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register writes
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	// Pads
	input wire logic [7:0] pad_f_in,
	input wire logic [7:0] pad_f_out,
	input wire logic [7:0] pad_f_oe_n,
	input wire logic [7:0] pad_g_oe_n,
	input wire logic [7:0] pad_h_in,
	input wire logic [7:0] pad_h_out,
	input wire logic [7:0] pad_h_oe_n,
	input wire logic pad_i_oe_n,
	// Peripherals
	input wire logic cam_one_line_sync,
	input wire logic cam_one_base_clock_out,
	input wire logic card_enable_high_n,
	input wire logic card_wait_request_n,
	input wire logic card_reset_out,
	input wire logic sd_card_detect_n,
	input wire logic sd_clock_out
);
	// ==========
	// Shadow of the port F and port H select registers
	logic [ADDR_W-1:0] aw_q;
	logic [15:0] wd_q;
	logic [15:0] sel_f;
	logic [15:0] sel_h;
	logic b_q;
	always_ff @(posedge aclk) begin
		if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[15:0];
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			b_q <= 1'b0;
			sel_f <= 16'h0000;
			sel_h <= 16'h0000;
		end else begin
			b_q <= s_axi_bvalid;
			if (s_axi_bvalid && !b_q && aw_q[7:0] == 8'h00) sel_f <= wd_q;
			if (s_axi_bvalid && !b_q && aw_q[7:0] == 8'h08) sel_h <= wd_q;
		end
	end
	// ==========
	// Properties
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wait_low_held;
		(sel_h[9:8] == 2'b01 && !pad_h_in[4]) [*7];
	endsequence
	sequence detect_low_held;
		(sel_h[13:12] == 2'b10 && !pad_h_in[6]) [*7];
	endsequence
	gpio_after_reset_a: assert property (
		$rose(aresetn) |-> &{pad_f_oe_n, pad_g_oe_n, pad_h_oe_n, pad_i_oe_n})
		else $error("pads driven right after reset");
	base_clock_out_a: assert property (
		sel_f[5:4] == 2'b01 |-> !pad_f_oe_n[2] && pad_f_out[2] == $past(cam_one_base_clock_out))
		else $error("camera base clock not on its pad");
	line_sync_a: assert property (
		cam_one_line_sync |-> $past(pad_f_in[1], 4) || $past(pad_f_in[1], 5))
		else $error("line sync high without pad cause");
	spare_code_a: assert property (
		sel_f[5:4] == 2'b11 |-> pad_f_oe_n[2])
		else $error("spare code drives pad");
	card_enable_a: assert property (
		sel_h[1:0] == 2'b01 |-> !pad_h_oe_n[0] && pad_h_out[0] == $past(card_enable_high_n))
		else $error("card enable not on its pad");
	reset_or_clock_a: assert property (
		sel_h[11:10] inside {2'b01, 2'b10} |-> !pad_h_oe_n[5] && pad_h_out[5] ==
		(sel_h[11:10] == 2'b01 ? $past(card_reset_out) : $past(sd_clock_out)))
		else $error("wrong source on card reset pad");
	wait_request_a: assert property (
		wait_low_held |-> !card_wait_request_n)
		else $error("wait request not passed");
	card_detect_a: assert property (
		detect_low_held |-> !sd_card_detect_n)
		else $error("card detect not passed");
endmodule

bind ccpm_pin_mux ccpm_pin_mux_props #(.ADDR_W(ADDR_W)) u_ccpm_pin_mux_props (
	.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .pad_f_in, .pad_f_out, .pad_f_oe_n,
	.pad_g_oe_n, .pad_h_in, .pad_h_out, .pad_h_oe_n, .pad_i_oe_n, .cam_one_line_sync,
	.cam_one_base_clock_out, .card_enable_high_n, .card_wait_request_n, .card_reset_out,
	.sd_card_detect_n, .sd_clock_out
);
`default_nettype wire

// ---- ccpm_pkg.sv ----
// Types shared by the camera/card pin multiplexer.
// Assumes ccpm_consts.svh is on the include path.
`default_nettype none
`include "ccpm_consts.svh"

package ccpm_pkg;
	// ==================================================
	// Pin function field codes
	typedef enum logic [1:0] {
		CCPM_FN_GPIO = 2'b00,
		CCPM_FN_ALT1 = 2'b01,
		CCPM_FN_ALT2 = 2'b10,
		CCPM_FN_SPARE = 2'b11
	} ccpm_fn_e;
	typedef logic [7:0] ccpm_pads_t;
endpackage
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the camera/card pin multiplexer.
// Assumes the far-side model resolves the pads and the checker is bound.
`timescale 1ns/100ps
`default_nettype none
module tb;
	// ==========
	// Signals
	logic aclk = 1'b0;
	logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, slow_pclk;
	logic pad_i_in, pad_i_out, pad_i_oe_n, cam_one_line_sync, cam_one_pixel_clock_in;
	logic cam_two_frame_sync, cam_two_line_sync, cam_two_pixel_clock_in, card_wait_request_n;
	logic card_interrupt_in, card_status_change_n, sd_command_line_in, sd_card_detect_n;
	logic sd_write_protect, cam_one_base_clock_out, cam_two_base_clock_out, card_enable_high_n;
	logic card_enable_low_n, card_io_read_strobe_n, card_io_write_strobe_n, card_reset_out;
	logic card_buffer_enable_n, sd_clock_out, sd_general_output, sd_command_line_out;
	logic sd_command_line_oe_n;
	logic [7:0] s_axi_awaddr, s_axi_araddr, pad_f_in, pad_f_out, pad_f_oe_n, pad_g_in, pad_g_out;
	logic [7:0] pad_g_oe_n, pad_h_in, pad_h_out, pad_h_oe_n, cam_two_pixel_bus, cam_data, card_lines;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
	logic [3:0] s_axi_wstrb, sd_data_line_out, sd_data_line_oe_n, sd_data_line_in;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [2:0] cam_syncs;
	logic [11:0] ctl;
	int err_count = 0;
	int n_checks = 0;
	int cycles = 0;
	assign {cam_one_base_clock_out, cam_two_base_clock_out, card_enable_high_n, card_enable_low_n,
		card_io_read_strobe_n, card_io_write_strobe_n, card_reset_out, card_buffer_enable_n,
		sd_clock_out, sd_general_output, sd_command_line_out, sd_command_line_oe_n} = ctl;
	ccpm_pin_mux u_ccpm_pin_mux (.*);
	ccpm_far_side u_ccpm_far_side (.*);
	always #2 aclk = ~aclk;
	// ==========
	// Helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				resp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				rd_data = s_axi_rdata;
				resp = s_axi_rresp;
				s_axi_rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	// ==========
	// Scenarios
	task automatic t_reset();
		@(posedge aclk);
		aresetn <= 1'b0;
		tick(8);
		aresetn <= 1'b1;
		tick(1);
		chk({pad_f_oe_n, pad_g_oe_n, pad_h_oe_n, 7'h00, pad_i_oe_n}, 32'hffffff01);
		for (int i = 0; i < 4; i++) begin
			rd(8'(4 * i));
			chk(rd_data, 32'h00000000);
		end
	endtask
	task automatic t_camera();
		wr(8'h00, 32'h00005554);
		wr(8'h04, 32'h00005555);
		for (int s = 0; s < 4; s++) begin
			slow_pclk <= s[0];
			ctl <= s[1] ? 12'hc00 : 12'h000;
			cam_syncs <= s[1] ? 3'b101 : 3'b010;
			cam_data <= s[1] ? 8'h96 : 8'h69;
			tick(10);
			chk({pad_f_oe_n, pad_g_oe_n, pad_f_out & 8'h44, 8'h00},
				s[1] ? 32'hbbff4400 : 32'hbbff0000);
			chk({19'h0, cam_one_line_sync, cam_two_frame_sync, cam_two_line_sync,
				cam_one_pixel_clock_in, cam_two_pixel_clock_in, cam_two_pixel_bus},
				s[1] ? 32'h00001796 : 32'h00000869);
		end
	endtask
	task automatic t_card_one();
		wr(8'h08, 32'h00005555);
		wr(8'h0c, 32'h00000001);
		for (int s = 0; s < 2; s++) begin
			ctl <= s[0] ? 12'h2a5 : 12'h15a;
			card_lines <= s[0] ? 8'h2f : 8'hff;
			tick(10);
			chk({16'h0, pad_h_oe_n, 7'h0, pad_i_oe_n}, 32'h0000d000);
			chk({16'h0, pad_h_out & 8'h2f, 7'h0, pad_i_out},
				s[0] ? 32'h00002500 : 32'h00000a01);
			chk({29'h0, card_wait_request_n, card_interrupt_in, card_status_change_n},
				s[0] ? 32'h0 : 32'h7);
		end
	endtask
	task automatic t_card_two();
		wr(8'h08, 32'h0000aaaa);
		wr(8'h0c, 32'h00000002);
		for (int s = 0; s < 2; s++) begin
			ctl <= s[0] ? 12'h00d : 12'h002;
			sd_data_line_out <= s[0] ? 4'h9 : 4'h6;
			sd_data_line_oe_n <= s[0] ? 4'hf : 4'h0;
			card_lines <= s[0] ? 8'h86 : 8'h4f;
			tick(10);
			chk({16'h0, pad_h_oe_n, 7'h0, pad_i_oe_n},
				s[0] ? 32'h0000df00 : 32'h0000c000);
			chk({16'h0, pad_h_out & (s[0] ? 8'h20 : 8'h3f), 7'h0, pad_i_out},
				s[0] ? 32'h00002001 : 32'h00001600);
			chk({30'h0, sd_card_detect_n, sd_write_protect}, s[0] ? 32'h1 : 32'h2);
		end
		chk({27'h0, sd_data_line_in, sd_command_line_in}, 32'h0000000c);
	endtask
	task automatic t_spare();
		wr(8'h00, 32'h0000ffff);
		wr(8'h08, 32'h0000ffff);
		wr(8'h40, 32'h00000001);
		chk(32'(resp), 32'h00000002);
		rd(8'h08);
		chk(rd_data, 32'h0000ffff);
		rd(8'h40);
		chk({rd_data[29:0], resp}, 32'h00000002);
		tick(10);
		chk({16'h0, pad_f_oe_n, pad_h_oe_n}, 32'h0000ffff);
		chk({29'h0, cam_one_line_sync, cam_two_line_sync, card_wait_request_n}, 32'h1);
	endtask
	task automatic t_gpio();
		wr(8'h04, 32'h00000000);
		wr(8'h14, 32'h0000005a);
		wr(8'h24, 32'h000000ff);
		tick(10);
		chk({16'h0, pad_g_oe_n, pad_g_out}, 32'h0000005a);
		rd(8'h34);
		chk(rd_data, 32'h0000005a);
		rd(8'h24);
		chk(rd_data, 32'h000000ff);
	endtask
	// ==========
	// Main sequence and timeout
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			wrap_up();
		end
	end
	initial begin
		aresetn = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hf;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		ctl = 12'h001;
		sd_data_line_out = 4'h0;
		sd_data_line_oe_n = 4'hf;
		slow_pclk = 1'b0;
		cam_syncs = 3'b000;
		cam_data = 8'h00;
		card_lines = 8'hff;
		t_reset();
		t_camera();
		t_card_one();
		t_card_two();
		t_spare();
		t_gpio();
		t_reset();
		wrap_up();
	end
endmodule
`default_nettype wire
